// ===== sim/tb_raster_setup_parameter_regs.sv
// Self-checking bench for the raster setup parameter register bank.
// Assumes the design package, a 50 MHz clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module tb_raster_setup_parameter_regs
  import raster_setup_pkg::*;
;
  typedef struct packed {
    logic [15:0] adr;
    logic [31:0] wr;
    logic [31:0] rd;
  } row_t;

  logic              clk_i;
  logic              rst_i;
  logic              cyc_i;
  logic              stb_i;
  logic              we_i;
  logic [3:0]        sel_i;
  logic [ADDR_W-1:0] adr_i;
  logic [31:0]       dat_i;
  logic [31:0]       dat_o;
  logic              ack_o;
  logic              err_o;
  logic [10:0]       line_count_o;
  logic              line_left_to_right_o;
  logic [19:0]       tex_base_v_o;
  logic [19:0]       tex_base_u_o;
  uv_format_t        uv_format_o;
  logic [31:0]       w_accum_o;
  logic [31:0]       d_accum_o;
  logic [31:0]       u_accum_o;
  logic [31:0]       v_accum_o;
  logic [31:0]       q;
  logic              e;
  int                n_mismatch;
  int                samples_checked;
  int                i;
  row_t              rows [13];

  raster_setup_parameter_regs raster_setup_parameter_regs_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .line_count_o(line_count_o),
    .line_left_to_right_o(line_left_to_right_o),
    .tex_base_v_o(tex_base_v_o), .tex_base_u_o(tex_base_u_o),
    .uv_format_o(uv_format_o), .w_accum_o(w_accum_o),
    .d_accum_o(d_accum_o), .u_accum_o(u_accum_o), .v_accum_o(v_accum_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check32(input string n, input logic [31:0] x,
                         input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  // One classic cycle; the answer is sampled at a rising edge, where the
  // data is taken and the request is released.
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1 || err_o === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      $display("Error bus answer expected ack seen none");
      print_verdict();
    end
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic acc(input logic [31:0] c, input logic [31:0] xw,
                     input logic [31:0] xd, input logic [31:0] xu,
                     input logic [31:0] xv);
    bus(1'b1, OFF_ACCUM_CTRL, c, 4'hf);
    @(posedge clk_i);
    @(negedge clk_i);
    check32("w_accum", xw, w_accum_o);
    check32("d_accum", xd, d_accum_o);
    check32("u_accum", xu, u_accum_o);
    check32("v_accum", xv, v_accum_o);
  endtask

  initial begin
    rows = '{'{16'hab1c, 32'hffff_ffff, 32'h8000_07ff},
             '{16'hb504, 32'hffff_ffff, 32'h000f_ffff},
             '{16'hb508, 32'h1234_5678, 32'h0004_5678},
             '{16'hb50c, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
             '{16'hb510, 32'h5a5a_a5a5, 32'h5a5a_a5a5},
             '{16'hb514, 32'h7fff_0001, 32'h7fff_0001},
             '{16'hb518, 32'h8000_0001, 32'h8000_0001},
             '{16'hb51c, 32'h0123_4567, 32'h0123_4567},
             '{16'hb520, 32'h89ab_cdef, 32'h89ab_cdef},
             '{16'hb524, 32'hfedc_ba98, 32'hfedc_ba98},
             '{16'hb528, 32'h7654_3210, 32'h7654_3210},
             '{16'hb52c, 32'h0f0f_f0f0, 32'h0f0f_f0f0},
             '{16'hb5f0, 32'h0000_0000, 32'h0000_0000}};
    n_mismatch = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    sel_i = 4'h0;
    adr_i = 16'h0000;
    dat_i = 32'h0000_0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFF_LINE_COUNT_DIR, 32'h0, 4'hf);
    check32("reset read", 32'h0, q);
    $display("test reset done");
    for (i = 0; i < 13; i++) bus(1'b1, rows[i].adr, rows[i].wr, 4'hf);
    for (i = 0; i < 13; i++) begin
      bus(1'b0, rows[i].adr, 32'h0, 4'hf);
      check32("read", rows[i].rd, q);
      check32("err", 32'h0, {31'h0, e});
    end
    check32("line_count", 32'h7ff, {21'h0, line_count_o});
    check32("dir", 32'h1, {31'h0, line_left_to_right_o});
    check32("tex_v", 32'hfffff, {12'h0, tex_base_v_o});
    check32("tex_u", 32'h45678, {12'h0, tex_base_u_o});
    $display("test rows done");
    bus(1'b1, OFF_LINE_COUNT_DIR, 32'h7fff_f123, 4'hf);
    @(negedge clk_i);
    check32("line_count", 32'h123, {21'h0, line_count_o});
    check32("dir", 32'h0, {31'h0, line_left_to_right_o});
    bus(1'b1, OFF_W_STEP_X, 32'h0000_0011, 4'h1);
    bus(1'b0, OFF_W_STEP_X, 32'h0, 4'hf);
    check32("byte sel", 32'ha5a5_5a11, q);
    bus(1'b0, 16'hb530, 32'h0, 4'hf);
    check32("unmapped err", 32'h1, {31'h0, e});
    check32("unmapped data", 32'h0, q);
    $display("test fields done");
    for (i = 0; i < 16; i++) begin
      bus(1'b1, OFF_COMMAND, {20'h0, 4'(15 - i), 4'(i), 4'h0}, 4'hf);
      @(negedge clk_i);
      check32("uv_format", {27'h0, 1'(i == 5 || i == 6), 4'(15 - i)},
              {27'h0, uv_format_o});
    end
    $display("test formats done");
    bus(1'b1, OFF_W_INITIAL, 32'h0010_0000, 4'hf);
    bus(1'b1, OFF_W_STEP_X, 32'h0000_0100, 4'hf);
    bus(1'b1, OFF_W_STEP_Y, 32'h0000_1000, 4'hf);
    bus(1'b1, OFF_D_STEP_X, 32'h0000_0010, 4'hf);
    bus(1'b1, OFF_D_STEP_Y, 32'h0000_0200, 4'hf);
    bus(1'b1, OFF_U_STEP_X, 32'h0000_0003, 4'hf);
    bus(1'b1, OFF_U_STEP_Y, 32'h0000_0040, 4'hf);
    bus(1'b1, OFF_V_STEP_X, 32'h0000_0005, 4'hf);
    bus(1'b1, OFF_V_STEP_Y, 32'h0000_0080, 4'hf);
    acc(32'h4, 32'h0010_0000, 32'h0, 32'h0, 32'h0);
    acc(32'h2, 32'h0010_0100, 32'h10, 32'h3, 32'h5);
    acc(32'h2, 32'h0010_0200, 32'h20, 32'h6, 32'ha);
    acc(32'h1, 32'h0010_1000, 32'h200, 32'h40, 32'h80);
    acc(32'h2, 32'h0010_1100, 32'h210, 32'h43, 32'h85);
    bus(1'b1, OFF_W_ACCUM, 32'hffff_ffff, 4'hf);
    bus(1'b0, OFF_W_ACCUM, 32'h0, 4'hf);
    check32("w readback", 32'h0010_1100, q);
    acc(32'h7, 32'h0010_0000, 32'h0, 32'h0, 32'h0);
    $display("test accumulators done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check32("reset count", 32'h0, {21'h0, line_count_o});
    check32("reset w", 32'h0, w_accum_o);
    @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFF_W_STEP_Y, 32'h0, 4'hf);
    check32("reset step", 32'h0, q);
    check32("reset err", 32'h0, {31'h0, e});
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb_raster_setup_parameter_regs

`default_nettype wire

// ===== src/raster_setup_parameter_regs.sv
// Raster setup parameter register bank with W, D, U and V accumulators.
// Assumes a classic Wishbone master on one 50 MHz clock.
// Behaviour
// - Line count register holds an 11-bit scanline count; bits 30-11 read zero.
// - Bit 31 selects direction: 0 right to left, 1 left to right.
// - Texture base vertical is 20 bits, format (4+s).(16-s); upper bits zero.
// - Texture base horizontal is 20 bits, same format; upper twelve bits zero.
// - W per-X and per-Y increments are 32-bit signed 12.19 values.
// - W is accumulated from its start value and serves as texture depth.
// - D per-X and per-Y increments are 32-bit signed 4.27 values.
// - Command 0101b or 0110b gives U and V increments format S(4+s).(27-s).
// - Otherwise U and V increments use sign, 12 integer, 8 filter, 11 fraction.
// - Shift s equals the mipmap level count in command bits 11 to 8.
// - Four separate registers hold U and V increments per X and per Y.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module raster_setup_parameter_regs
  import raster_setup_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  output logic                   err_o,
  output logic      [10:0]       line_count_o,
  output logic                   line_left_to_right_o,
  output logic      [19:0]       tex_base_v_o,
  output logic      [19:0]       tex_base_u_o,
  output uv_format_t             uv_format_o,
  output logic      [31:0]       w_accum_o,
  output logic      [31:0]       d_accum_o,
  output logic      [31:0]       u_accum_o,
  output logic      [31:0]       v_accum_o
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] line_reg;
  logic [31:0] base_v;
  logic [31:0] base_u;
  logic [31:0] command;
  logic [31:0] w_init;
  logic [31:0] w_sx;
  logic [31:0] w_sy;
  logic [31:0] d_sx;
  logic [31:0] d_sy;
  logic [31:0] u_sx;
  logic [31:0] u_sy;
  logic [31:0] v_sx;
  logic [31:0] v_sy;
  logic [31:0] w_acc;
  logic [31:0] d_acc;
  logic [31:0] u_acc;
  logic [31:0] v_acc;
  logic [31:0] w_row;
  logic [31:0] d_row;
  logic [31:0] u_row;
  logic [31:0] v_row;
  logic        ack;

  wire         req     = cyc_i & stb_i & ~ack & ~err_o;
  wire         wr      = req & we_i;
  wire         ctrl_wr = wr & (adr_i == OFF_ACCUM_CTRL);
  accum_ctrl_t ctrl;
  assign ctrl = ctrl_wr ? accum_ctrl_t'(dat_i[2:0]) : 3'b000;

  wire hit_line = adr_i == OFF_LINE_COUNT_DIR;
  wire hit_bv   = adr_i == OFF_TEX_BASE_V;
  wire hit_bu   = adr_i == OFF_TEX_BASE_U;
  wire hit_cmd  = adr_i == OFF_COMMAND;
  wire hit_wi   = adr_i == OFF_W_INITIAL;
  wire hit_wx   = adr_i == OFF_W_STEP_X;
  wire hit_wy   = adr_i == OFF_W_STEP_Y;
  wire hit_dx   = adr_i == OFF_D_STEP_X;
  wire hit_dy   = adr_i == OFF_D_STEP_Y;
  wire hit_ux   = adr_i == OFF_U_STEP_X;
  wire hit_uy   = adr_i == OFF_U_STEP_Y;
  wire hit_vx   = adr_i == OFF_V_STEP_X;
  wire hit_vy   = adr_i == OFF_V_STEP_Y;
  wire hit_ctl  = adr_i == OFF_ACCUM_CTRL;
  wire hit_wa   = adr_i == OFF_W_ACCUM;
  wire mapped   = hit_line | hit_bv | hit_bu | hit_cmd | hit_wi | hit_wx |
                  hit_wy | hit_dx | hit_dy | hit_ux | hit_uy | hit_vx |
                  hit_vy | hit_ctl | hit_wa;

  wire [31:0] line_mask = {1'b1, 20'h0_0000, 11'h7ff};
  wire [31:0] base_mask = {12'h000, 20'hfffff};

  wire [3:0] cmd3d = command[CMD3D_MSB:CMD3D_LSB];
  assign uv_format_o.perspective = (cmd3d == CMD_PERSP_A) |
                                   (cmd3d == CMD_PERSP_B);
  assign uv_format_o.shift = command[MIP_MSB:MIP_LSB];

  logic [31:0] rdata;
  always_comb begin
    if (hit_line) begin
      rdata = line_reg & line_mask;
    end else if (hit_bv) begin
      rdata = base_v & base_mask;
    end else if (hit_bu) begin
      rdata = base_u & base_mask;
    end else if (hit_cmd) begin
      rdata = command;
    end else if (hit_wi) begin
      rdata = w_init;
    end else if (hit_wx) begin
      rdata = w_sx;
    end else if (hit_wy) begin
      rdata = w_sy;
    end else if (hit_dx) begin
      rdata = d_sx;
    end else if (hit_dy) begin
      rdata = d_sy;
    end else if (hit_ux) begin
      rdata = u_sx;
    end else if (hit_uy) begin
      rdata = u_sy;
    end else if (hit_vx) begin
      rdata = v_sx;
    end else if (hit_vy) begin
      rdata = v_sy;
    end else if (hit_wa) begin
      rdata = w_acc;
    end else begin
      rdata = RESET_WORD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      err_o <= 1'b0;
      dat_o <= RESET_WORD;
    end else begin
      ack   <= req & mapped;
      err_o <= req & ~mapped;
      dat_o <= (req & ~we_i) ? rdata : RESET_WORD;
    end
  end
  assign ack_o = ack;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_reg <= RESET_WORD;
      base_v   <= RESET_WORD;
      base_u   <= RESET_WORD;
      command  <= RESET_WORD;
      w_init   <= RESET_WORD;
      w_sx     <= RESET_WORD;
      w_sy     <= RESET_WORD;
      d_sx     <= RESET_WORD;
      d_sy     <= RESET_WORD;
      u_sx     <= RESET_WORD;
      u_sy     <= RESET_WORD;
      v_sx     <= RESET_WORD;
      v_sy     <= RESET_WORD;
    end else if (wr) begin
      if (hit_line) line_reg <= merge(line_reg, dat_i, sel_i) & line_mask;
      if (hit_bv)   base_v   <= merge(base_v, dat_i, sel_i) & base_mask;
      if (hit_bu)   base_u   <= merge(base_u, dat_i, sel_i) & base_mask;
      if (hit_cmd)  command  <= merge(command, dat_i, sel_i);
      if (hit_wi)   w_init   <= merge(w_init, dat_i, sel_i);
      if (hit_wx)   w_sx     <= merge(w_sx, dat_i, sel_i);
      if (hit_wy)   w_sy     <= merge(w_sy, dat_i, sel_i);
      if (hit_dx)   d_sx     <= merge(d_sx, dat_i, sel_i);
      if (hit_dy)   d_sy     <= merge(d_sy, dat_i, sel_i);
      if (hit_ux)   u_sx     <= merge(u_sx, dat_i, sel_i);
      if (hit_uy)   u_sy     <= merge(u_sy, dat_i, sel_i);
      if (hit_vx)   v_sx     <= merge(v_sx, dat_i, sel_i);
      if (hit_vy)   v_sy     <= merge(v_sy, dat_i, sel_i);
    end
  end

  // Row values hold the scanline start; a Y step advances the row and
  // restarts the span, an X step advances along the span.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_acc <= RESET_WORD;
      d_acc <= RESET_WORD;
      u_acc <= RESET_WORD;
      v_acc <= RESET_WORD;
      w_row <= RESET_WORD;
      d_row <= RESET_WORD;
      u_row <= RESET_WORD;
      v_row <= RESET_WORD;
    end else if (ctrl.load) begin
      w_acc <= w_init;
      w_row <= w_init;
      d_acc <= RESET_WORD;
      d_row <= RESET_WORD;
      u_acc <= RESET_WORD;
      u_row <= RESET_WORD;
      v_acc <= RESET_WORD;
      v_row <= RESET_WORD;
    end else if (ctrl.step_y) begin
      w_acc <= w_row + w_sy;
      w_row <= w_row + w_sy;
      d_acc <= d_row + d_sy;
      d_row <= d_row + d_sy;
      u_acc <= u_row + u_sy;
      u_row <= u_row + u_sy;
      v_acc <= v_row + v_sy;
      v_row <= v_row + v_sy;
    end else if (ctrl.step_x) begin
      w_acc <= w_acc + w_sx;
      d_acc <= d_acc + d_sx;
      u_acc <= u_acc + u_sx;
      v_acc <= v_acc + v_sx;
    end
  end

  assign line_count_o         = line_reg[LINE_COUNT_W-1:0];
  assign line_left_to_right_o = line_reg[DIR_BIT];
  assign tex_base_v_o         = base_v[TEX_BASE_W-1:0];
  assign tex_base_u_o         = base_u[TEX_BASE_W-1:0];
  assign w_accum_o            = w_acc;
  assign d_accum_o            = d_acc;
  assign u_accum_o            = u_acc;
  assign v_accum_o            = v_acc;

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_mapped_ack;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o && mapped) |=> ack_o && !err_o;
  endproperty
  a_mapped_ack: assert property (p_mapped_ack) else $error("no ack");

  property p_line_rsv;
    @(posedge clk_i) disable iff (rst_i)
      line_reg[30:11] == 20'h0_0000;
  endproperty
  a_line_rsv: assert property (p_line_rsv) else $error("line rsv");

  property p_dir;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit_line && sel_i[3]) |=> line_left_to_right_o == $past(dat_i[31]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction lost");

  property p_base_rsv;
    @(posedge clk_i) disable iff (rst_i)
      base_v[31:20] == 12'h000 && base_u[31:20] == 12'h000;
  endproperty
  a_base_rsv: assert property (p_base_rsv) else $error("base rsv");

  property p_base_u_wr;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit_bu && sel_i == 4'hf) |=> tex_base_u_o == $past(dat_i[19:0]);
  endproperty
  a_base_u_wr: assert property (p_base_u_wr) else $error("base u");

  property p_persp;
    @(posedge clk_i) disable iff (rst_i)
      uv_format_o.perspective == (command[7:4] inside {4'h5, 4'h6});
  endproperty
  a_persp: assert property (p_persp) else $error("perspective");

  property p_shift;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit_cmd && sel_i[1]) |=> uv_format_o.shift == $past(dat_i[11:8]);
  endproperty
  a_shift: assert property (p_shift) else $error("mip shift");

  property p_step_x;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl.step_x && !ctrl.step_y && !ctrl.load)
        |=> w_accum_o == $past(w_acc) + $past(w_sx);
  endproperty
  a_step_x: assert property (p_step_x) else $error("x step");

  property p_load_w;
    @(posedge clk_i) disable iff (rst_i)
      ctrl.load |=> w_accum_o == $past(w_init);
  endproperty
  a_load_w: assert property (p_load_w) else $error("w load");

  sequence s_span_step;
    ctrl.step_x && !ctrl.step_y && !ctrl.load;
  endsequence

  property p_err_one;
    @(posedge clk_i) disable iff (rst_i)
      err_o |=> !err_o;
  endproperty
  a_err_one: assert property (p_err_one) else $error("err held two cycles");

  property p_unmapped_err;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o && !err_o && !mapped) |=> err_o && !ack_o;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("no err");

  property p_base_v_wr;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit_bv && sel_i == 4'hf) |=> tex_base_v_o == $past(dat_i[19:0]);
  endproperty
  a_base_v_wr: assert property (p_base_v_wr) else $error("base v");

  property p_line_count_wr;
    @(posedge clk_i) disable iff (rst_i)
      (wr && hit_line && sel_i[1:0] == 2'h3)
        |=> line_count_o == $past(dat_i[10:0]);
  endproperty
  a_line_count_wr: assert property (p_line_count_wr) else $error("count");

  property p_step_y;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl.step_y && !ctrl.load)
        |=> w_accum_o == $past(w_row) + $past(w_sy);
  endproperty
  a_step_y: assert property (p_step_y) else $error("y step");

  property p_d_step_x;
    @(posedge clk_i) disable iff (rst_i)
      s_span_step |=> d_accum_o == $past(d_acc) + $past(d_sx);
  endproperty
  a_d_step_x: assert property (p_d_step_x) else $error("d step");

  property p_uv_step_x;
    @(posedge clk_i) disable iff (rst_i)
      s_span_step |=> u_accum_o == $past(u_acc) + $past(u_sx) &&
                      v_accum_o == $past(v_acc) + $past(v_sx);
  endproperty
  a_uv_step_x: assert property (p_uv_step_x) else $error("uv step");

  property p_read_w;
    @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_wx) |=> ack_o && dat_o == $past(w_sx);
  endproperty
  a_read_w: assert property (p_read_w) else $error("w step read");

endmodule // raster_setup_parameter_regs

`default_nettype wire

// ===== src/raster_setup_pkg.sv
// Package for the raster setup parameter register bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package raster_setup_pkg;

  localparam int ADDR_W = 16;

  localparam logic [15:0] OFF_LINE_COUNT_DIR = 16'hab1c;
  localparam logic [15:0] OFF_TEX_BASE_V     = 16'hb504;
  localparam logic [15:0] OFF_TEX_BASE_U     = 16'hb508;
  localparam logic [15:0] OFF_W_STEP_X       = 16'hb50c;
  localparam logic [15:0] OFF_W_STEP_Y       = 16'hb510;
  localparam logic [15:0] OFF_W_INITIAL      = 16'hb514;
  localparam logic [15:0] OFF_D_STEP_X       = 16'hb518;
  localparam logic [15:0] OFF_V_STEP_X       = 16'hb51c;
  localparam logic [15:0] OFF_U_STEP_X       = 16'hb520;
  localparam logic [15:0] OFF_D_STEP_Y       = 16'hb524;
  localparam logic [15:0] OFF_V_STEP_Y       = 16'hb528;
  localparam logic [15:0] OFF_U_STEP_Y       = 16'hb52c;
  localparam logic [15:0] OFF_COMMAND        = 16'hb500;
  localparam logic [15:0] OFF_ACCUM_CTRL     = 16'hb5f0;
  localparam logic [15:0] OFF_W_ACCUM        = 16'hb5f4;

  localparam int LINE_COUNT_W   = 11;
  localparam int DIR_BIT        = 31;
  localparam int TEX_BASE_W     = 20;
  localparam int MIP_LSB        = 8;
  localparam int MIP_MSB        = 11;
  localparam int CMD3D_LSB      = 4;
  localparam int CMD3D_MSB      = 7;
  localparam logic [3:0] CMD_PERSP_A = 4'h5;
  localparam logic [3:0] CMD_PERSP_B = 4'h6;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Interpreted format of the U and V increments.
  typedef struct packed {
    logic       perspective;
    logic [3:0] shift;
  } uv_format_t;

  // Accumulator step commands from the control register.
  typedef struct packed {
    logic load;
    logic step_x;
    logic step_y;
  } accum_ctrl_t;

endpackage
